/* File: rtl/core_addressing_mode_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module core_addressing_mode_decoder
    import addr_mode_pkg::*;
#(
    parameter int STACK_CELLS = STACK_DEPTH
)(
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic            run,
    input  wire logic [DW-1:0]   prog_rdata,
    input  wire logic [DW-1:0]   data_rdata,
    input  wire logic            zero_flag,
    output var  logic [PC_W-1:0] prog_addr,
    output var  logic            prog_rd,
    output var  logic [DW-1:0]   data_addr,
    output var  logic            data_rd,
    output var  logic            data_we,
    output var  logic [DW-1:0]   data_wdata,
    output var  logic [DW-1:0]   operand,
    output var  logic [DW-1:0]   eff_addr,
    output var  logic [2:0]      bit_sel,
    output var  logic [PC_W-1:0] target,
    output var  logic            branch_taken,
    output var  logic            carry,
    output var  mode_t           mode,
    output var  logic [PC_W-1:0] pc,
    output var  logic            done
);
    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_FETCH = 4'h1,
        S_OPC   = 4'h2,
        S_DEC   = 4'h3,
        S_BYTE2 = 4'h4,
        S_BYTE3 = 4'h5,
        S_PTR   = 4'h6,
        S_BITRD = 4'h7,
        S_DONE  = 4'h8
    } state_t;

    state_t          state;
    logic [DW-1:0]   opcode;
    logic [DW-1:0]   b2;
    logic [PC_W-1:0] resume;
    logic [PC_W-1:0] seq_pc;
    logic [PC_W-1:0] rel_pc;
    logic [PC_W-1:0] stack_top;
    logic [DW-1:0]   bit_mask;
    logic            rel_cond;
    logic            tested_bit;
    logic            push;
    logic            pop;
    logic            btb_hit;

    decode_if dec ();
    assign dec.opcode = opcode;

    opcode_classifier u_cls (
        .d (dec)
    );

    // Return addresses live apart from program and data space
    assign push = (state == S_BYTE2) && dec.is_call;
    assign pop  = (state == S_DEC) && dec.is_ret;

    return_stack #(
        .DEPTH (STACK_CELLS),
        .W     (PC_W)
    ) u_stack (
        .clk     (clk),
        .sys_rst (sys_rst),
        .push    (push),
        .pop     (pop),
        .din     (seq_pc),
        .top     (stack_top)
    );

    assign seq_pc     = pc + {{(PC_W-2){1'b0}}, dec.len};
    assign rel_pc     = opcode[REL_DIR_BIT] ? pc - {8'h00, opcode[3:0]}
                                            : pc + {8'h00, opcode[3:0]} + PC_ONE;
    assign bit_mask   = BIT_ONE << bit_sel;
    assign tested_bit = data_rdata[bit_sel];
    assign btb_hit    = (dec.mode == M_BTB) && (tested_bit == opcode[SUB_BIT]);

    always_comb begin
        case (test_kind_t'(opcode[6:5]))
            TEST_C_SET: rel_cond = carry;
            TEST_C_CLR: rel_cond = !carry;
            TEST_Z_SET: rel_cond = zero_flag;
            TEST_Z_CLR: rel_cond = !zero_flag;
            default:    rel_cond = 1'b0;
        endcase
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    if (run) begin
                        state <= S_FETCH;
                    end
                end
                S_FETCH: state <= S_OPC;
                S_OPC:   state <= S_DEC;
                S_DEC: begin
                    case (dec.mode)
                        M_REL, M_SDIR, M_INH: state <= S_DONE;
                        M_IND:                state <= S_PTR;
                        default:              state <= S_BYTE2;
                    endcase
                end
                S_BYTE2: begin
                    if (dec.len == LEN_3) begin
                        state <= S_BYTE3;
                    end else if (dec.mode == M_BITD) begin
                        state <= S_BITRD;
                    end else begin
                        state <= S_DONE;
                    end
                end
                S_BYTE3: state <= S_BITRD;
                S_PTR:   state <= S_DONE;
                S_BITRD: state <= S_DONE;
                S_DONE:  state <= run ? S_FETCH : S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Program-space fetch port
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prog_addr <= '0;
            prog_rd   <= 1'b0;
            opcode    <= '0;
            b2        <= '0;
        end else begin
            prog_rd <= 1'b0;
            case (state)
                S_FETCH: begin
                    prog_addr <= pc;
                    prog_rd   <= 1'b1;
                end
                S_OPC: opcode <= prog_rdata;
                S_DEC: begin
                    if (dec.len != LEN_1) begin
                        prog_addr <= pc + PC_ONE;
                        prog_rd   <= 1'b1;
                    end
                end
                S_BYTE2: begin
                    b2 <= prog_rdata;
                    if (dec.len == LEN_3) begin
                        prog_addr <= pc + PC_TWO;
                        prog_rd   <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Data-space port
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_addr  <= '0;
            data_rd    <= 1'b0;
            data_we    <= 1'b0;
            data_wdata <= '0;
        end else begin
            data_rd <= 1'b0;
            data_we <= 1'b0;
            case (state)
                S_DEC: begin
                    if (dec.mode == M_IND) begin
                        data_addr <= opcode[PTR_SEL_BIT] ? PTR_SECOND_ADDR
                                                         : PTR_FIRST_ADDR;
                        data_rd   <= 1'b1;
                    end
                end
                S_BYTE2: begin
                    if (dec.mode == M_BITD) begin
                        data_addr <= prog_rdata;
                        data_rd   <= 1'b1;
                    end
                end
                S_BYTE3: begin
                    data_addr <= b2;
                    data_rd   <= 1'b1;
                end
                S_BITRD: begin
                    if (dec.mode == M_BITD) begin
                        data_we    <= 1'b1;
                        data_wdata <= opcode[SUB_BIT] ? (data_rdata | bit_mask)
                                                      : (data_rdata & ~bit_mask);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Decoded results
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode         <= M_INH;
            bit_sel      <= '0;
            operand      <= '0;
            eff_addr     <= '0;
            target       <= '0;
            branch_taken <= 1'b0;
            done         <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                S_DEC: begin
                    mode         <= dec.mode;
                    bit_sel      <= opcode[2:0];
                    branch_taken <= 1'b0;
                    if (dec.mode == M_REL) begin
                        target       <= rel_pc;
                        branch_taken <= rel_cond;
                    end
                    if (dec.mode == M_SDIR) begin
                        eff_addr <= SDIR_BASE | {6'h00, opcode[1:0]};
                    end
                    if (dec.is_ret) begin
                        target       <= stack_top;
                        branch_taken <= 1'b1;
                    end
                end
                S_BYTE2: begin
                    case (dec.mode)
                        M_IMM: operand <= prog_rdata;
                        M_DIR, M_BITD, M_BTB: eff_addr <= prog_rdata;
                        M_EXT: begin
                            target       <= {opcode[3:0], prog_rdata};
                            branch_taken <= 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
                S_BYTE3: begin
                    target <= pc + {{(PC_W-DW){prog_rdata[DW-1]}}, prog_rdata} + PC_ONE;
                end
                S_PTR:   eff_addr <= data_rdata;
                S_BITRD: branch_taken <= btb_hit;
                S_DONE:  done <= 1'b1;
                default: begin
                end
            endcase
        end
    end

    // Program counter and carry
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc     <= '0;
            resume <= '0;
            carry  <= 1'b0;
        end else begin
            case (state)
                S_DEC: begin
                    resume <= seq_pc;
                    if (dec.mode == M_REL && rel_cond) begin
                        resume <= rel_pc;
                    end
                    if (dec.is_ret) begin
                        resume <= stack_top;
                    end
                end
                S_BYTE2: begin
                    if (dec.mode == M_EXT) begin
                        resume <= {opcode[3:0], prog_rdata};
                    end
                end
                S_BITRD: begin
                    carry <= tested_bit;
                    if (btb_hit) begin
                        resume <= target;
                    end
                end
                S_DONE:  pc <= resume;
                default: begin
                end
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic signed [PC_W-1:0] rel_span;
    assign rel_span = target - pc;

    sequence s_ind_start;
        state == S_DEC && dec.mode == M_IND;
    endsequence
    sequence s_ind_load;
        (data_rd && state == S_PTR
         && data_addr == (opcode[PTR_SEL_BIT] ? PTR_SECOND_ADDR : PTR_FIRST_ADDR))
        ##1 eff_addr == $past(data_rdata);
    endsequence
    sequence s_btb_fetch;
        (prog_rd && prog_addr == pc + PC_ONE) ##1 (prog_rd && prog_addr == pc + PC_TWO)
        ##1 (data_rd && data_addr == b2);
    endsequence

    property p_indirect;
        s_ind_start |=> s_ind_load;
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect address wrong");

    property p_btb_bytes;
        state == S_DEC && dec.mode == M_BTB |=> s_btb_fetch;
    endproperty
    a_btb_bytes: assert property (p_btb_bytes) else $error("bit test fetch wrong");

    property p_fetch;
        state == S_FETCH |=> prog_rd && prog_addr == $past(pc);
    endproperty
    a_fetch: assert property (p_fetch) else $error("opcode fetch not at pc");

    property p_imm;
        state == S_BYTE2 && dec.mode == M_IMM |=> operand == $past(prog_rdata)
            ##1 pc == $past(pc, 2) + PC_TWO;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate operand wrong");

    property p_dir;
        state == S_BYTE2 && dec.mode == M_DIR |=> eff_addr == $past(prog_rdata);
    endproperty
    a_dir: assert property (p_dir) else $error("direct address wrong");

    property p_sdir;
        state == S_DEC && dec.mode == M_SDIR |=> eff_addr[7:2] == SDIR_BASE[7:2]
            && eff_addr[1:0] == $past(opcode[1:0]);
    endproperty
    a_sdir: assert property (p_sdir) else $error("short direct address wrong");

    property p_ext;
        state == S_BYTE2 && dec.mode == M_EXT
            |=> target == {$past(opcode[3:0]), $past(prog_rdata)} ##1 pc == $past(target);
    endproperty
    a_ext: assert property (p_ext) else $error("extended target wrong");

    property p_rel;
        state == S_DEC && dec.mode == M_REL && rel_cond
            |=> branch_taken && rel_span >= REL_MIN && rel_span <= REL_MAX;
    endproperty
    a_rel: assert property (p_rel) else $error("relative target out of span");

    property p_rel_miss;
        state == S_DEC && dec.mode == M_REL && !rel_cond
            |=> !branch_taken ##1 pc == $past(pc, 2) + PC_ONE;
    endproperty
    a_rel_miss: assert property (p_rel_miss) else $error("untaken branch wrong");

    property p_carry;
        state == S_BITRD |=> carry == $past(tested_bit);
    endproperty
    a_carry: assert property (p_carry) else $error("carry not loaded");

    property p_bit_write;
        state == S_BITRD && dec.mode == M_BITD
            |=> data_we && data_addr == eff_addr && data_wdata[bit_sel] == opcode[SUB_BIT];
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("bit write wrong");

    property p_inherent;
        state == S_DEC && dec.mode == M_INH |=> state == S_DONE && !prog_rd && !data_rd;
    endproperty
    a_inherent: assert property (p_inherent) else $error("inherent fetched operand");
endmodule
`default_nettype wire

/* File: include/addr_mode_pkg.sv */
// Behaviour
// - Program, data and stack spaces are kept apart on separate ports and storage.
// - Stack holds six 12-bit return addresses from calls.
// - Data space holds accumulator, four short registers, peripherals, RAM, data ROM.
// - Immediate operand is the program byte right after the opcode.
// - Direct mode uses the second byte as an 8-bit data address.
// - Short direct picks one of registers 80h..83h from an opcode field.
// - Extended address is four low opcode bits above the second byte.
// - Jump and call reach any address of the 4K program space.
// - One-byte relative branch lands -15..+16 from itself, else falls through.
// - Relative opcode: test kind, direction bit, four-bit span added or subtracted.
// - Bit direct: bit number in opcode, address in next byte, set or clear.
// - Bit set and bit clear load carry with the addressed bit.
// - Bit test branch: three bytes, bit and sense, address, displacement.
// - Indirect address comes from pointer 80h or 81h, chosen by opcode bit 4.
// - Inherent instructions are one byte with no operand fetch.
package addr_mode_pkg;
    localparam int PC_W        = 12;
    localparam int DW          = 8;
    localparam int STACK_DEPTH = 6;
    localparam int SUB_BIT     = 3;
    localparam int PTR_SEL_BIT = 4;
    localparam int REL_DIR_BIT = 4;
    localparam int REL_MIN     = -15;
    localparam int REL_MAX     = 16;

    // Data-space register locations and single-bit mask
    localparam logic [7:0] PTR_FIRST_ADDR   = 8'h80;
    localparam logic [7:0] PTR_SECOND_ADDR  = 8'h81;
    localparam logic [7:0] SD_THIRD_ADDR    = 8'h82;
    localparam logic [7:0] SD_FOURTH_ADDR   = 8'h83;
    localparam logic [7:0] SDIR_BASE        = 8'h80;
    localparam logic [7:0] BIT_ONE          = 8'h01;

    // Opcode map, upper nibble, top three bits and low return field
    localparam logic [3:0] NIB_EXT_JUMP     = 4'h8;
    localparam logic [3:0] NIB_EXT_CALL     = 4'h9;
    localparam logic [3:0] NIB_BIT_DIRECT   = 4'hA;
    localparam logic [3:0] NIB_BIT_TEST     = 4'hB;
    localparam logic [3:0] NIB_IMM_SDIR     = 4'hC;
    localparam logic [3:0] NIB_DIR_INH      = 4'hD;
    localparam logic [2:0] TOP_INDIRECT     = 3'h7;
    localparam logic [2:0] INH_RETURN       = 3'h0;

    localparam logic [1:0] LEN_1            = 2'h1;
    localparam logic [1:0] LEN_2            = 2'h2;
    localparam logic [1:0] LEN_3            = 2'h3;
    localparam logic [PC_W-1:0] PC_ONE      = 12'h001;
    localparam logic [PC_W-1:0] PC_TWO      = 12'h002;

    typedef enum logic [3:0] {
        M_IMM  = 4'h0,
        M_DIR  = 4'h1,
        M_SDIR = 4'h2,
        M_EXT  = 4'h3,
        M_REL  = 4'h4,
        M_BITD = 4'h5,
        M_BTB  = 4'h6,
        M_IND  = 4'h7,
        M_INH  = 4'h8
    } mode_t;

    typedef enum logic [1:0] {
        TEST_C_SET = 2'h0,
        TEST_C_CLR = 2'h1,
        TEST_Z_SET = 2'h2,
        TEST_Z_CLR = 2'h3
    } test_kind_t;
endpackage

/* File: include/decode_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
    import addr_mode_pkg::*;
    logic [DW-1:0] opcode;
    mode_t         mode;
    logic [1:0]    len;
    logic          is_call;
    logic          is_ret;

    modport classify (input opcode, output mode, len, is_call, is_ret);
    modport core     (output opcode, input mode, len, is_call, is_ret);
endinterface
`default_nettype wire

/* File: rtl/opcode_classifier.sv */
`timescale 1ns/1ps
`default_nettype none
module opcode_classifier
    import addr_mode_pkg::*;
(
    decode_if.classify d
);
    always_comb begin
        d.mode    = M_INH;
        d.len     = LEN_1;
        d.is_call = 1'b0;
        d.is_ret  = 1'b0;
        if (!d.opcode[7]) begin
            d.mode = M_REL;
        end else if (d.opcode[7:5] == TOP_INDIRECT) begin
            d.mode = M_IND;
        end else begin
            case (d.opcode[7:4])
                NIB_EXT_JUMP, NIB_EXT_CALL: begin
                    d.mode    = M_EXT;
                    d.len     = LEN_2;
                    d.is_call = (d.opcode[7:4] == NIB_EXT_CALL);
                end
                NIB_BIT_DIRECT: begin
                    d.mode = M_BITD;
                    d.len  = LEN_2;
                end
                NIB_BIT_TEST: begin
                    d.mode = M_BTB;
                    d.len  = LEN_3;
                end
                NIB_IMM_SDIR: begin
                    d.mode = d.opcode[SUB_BIT] ? M_SDIR : M_IMM;
                    d.len  = d.opcode[SUB_BIT] ? LEN_1 : LEN_2;
                end
                NIB_DIR_INH: begin
                    d.mode   = d.opcode[SUB_BIT] ? M_INH : M_DIR;
                    d.len    = d.opcode[SUB_BIT] ? LEN_1 : LEN_2;
                    d.is_ret = d.opcode[SUB_BIT] && (d.opcode[2:0] == INH_RETURN);
                end
                default: begin
                    d.mode = M_INH;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: rtl/return_stack.sv */
`timescale 1ns/1ps
`default_nettype none
module return_stack #(
    parameter int DEPTH = 6,
    parameter int W     = 12
)(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         push,
    input  wire logic         pop,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] top
);
    logic [W-1:0] cells [DEPTH];
    logic [3:0]   count;

    // Push on a full stack is dropped, pop on empty returns zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= 4'h0;
        end else if (push && count < 4'(DEPTH)) begin
            cells[count[2:0]] <= din;
            count             <= count + 4'h1;
        end else if (pop && count != 4'h0) begin
            count <= count - 4'h1;
        end
    end

    assign top = (count == 4'h0) ? '0 : cells[3'(count - 4'h1)];

    property p_stack_bound;
        @(posedge clk) disable iff (sys_rst) count <= 4'(DEPTH);
    endproperty
    a_stack_bound: assert property (p_stack_bound) else $error("stack overfilled");
endmodule
`default_nettype wire

/* File: verification/core_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_mem_model
    import addr_mode_pkg::*;
(
    input  wire logic            clk,
    input  wire logic [PC_W-1:0] prog_addr,
    input  wire logic            prog_rd,
    input  wire logic [DW-1:0]   data_addr,
    input  wire logic            data_rd,
    input  wire logic            data_we,
    input  wire logic [DW-1:0]   data_wdata,
    output logic      [DW-1:0]   prog_rdata,
    output logic      [DW-1:0]   data_rdata
);
    logic [DW-1:0] prog_mem [0:4095];
    logic [DW-1:0] data_mem [0:255];
    logic [DW-1:0] prog_last = 8'h00;
    logic [DW-1:0] data_last = 8'h00;

    // Separate program and data stores; idle bus shows inverted last byte
    assign prog_rdata = prog_rd ? prog_mem[prog_addr] : ~prog_last;
    assign data_rdata = data_rd ? data_mem[data_addr] : ~data_last;

    always @(posedge clk) begin
        if (prog_rd)
            prog_last <= prog_mem[prog_addr];
        if (data_rd)
            data_last <= data_mem[data_addr];
        // Pointer and short registers at 80h..83h live here too
        if (data_we)
            data_mem[data_addr] <= data_wdata;
    end
endmodule
`default_nettype wire

/* File: verification/test_core_addressing_mode_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module test_core_addressing_mode_decoder;
    import addr_mode_pkg::*;
    logic            clk = 1'b0;
    logic            sys_rst, run, zero_flag;
    logic [DW-1:0]   prog_rdata, data_rdata, data_addr, data_wdata, operand, eff_addr;
    logic [PC_W-1:0] prog_addr, target, pc;
    logic            prog_rd, data_rd, data_we, branch_taken, carry, done;
    logic [2:0]      bit_sel;
    mode_t           mode;
    int              fail_count = 0;
    int              num_checks = 0;
    logic [PC_W-1:0] cur_pc = 12'h000;

    core_addressing_mode_decoder core_addressing_mode_decoder_inst (
        .clk(clk), .sys_rst(sys_rst), .run(run), .prog_rdata(prog_rdata),
        .data_rdata(data_rdata), .zero_flag(zero_flag), .prog_addr(prog_addr),
        .prog_rd(prog_rd), .data_addr(data_addr), .data_rd(data_rd), .data_we(data_we),
        .data_wdata(data_wdata), .operand(operand), .eff_addr(eff_addr),
        .bit_sel(bit_sel), .target(target), .branch_taken(branch_taken),
        .carry(carry), .mode(mode), .pc(pc), .done(done));

    core_mem_model core_mem_model_inst (
        .clk(clk), .prog_addr(prog_addr), .prog_rd(prog_rd), .data_addr(data_addr),
        .data_rd(data_rd), .data_we(data_we), .data_wdata(data_wdata),
        .prog_rdata(prog_rdata), .data_rdata(data_rdata));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Load one instruction at cur_pc, run it, check fetches, latency, mode and pc
    task automatic exec(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                        input int len, input mode_t m, input logic [PC_W-1:0] npc,
                        input int cyc);
        int n;
        int np;
        n = 0;
        np = 0;
        core_mem_model_inst.prog_mem[cur_pc] = b0;
        core_mem_model_inst.prog_mem[cur_pc + 12'h001] = b1;
        core_mem_model_inst.prog_mem[cur_pc + 12'h002] = b2;
        run = 1'b1;
        @(posedge clk);
        #1;
        run = 1'b0;
        while (done !== 1'b1 && n < 20) begin
            if (prog_rd === 1'b1) begin
                chk("prog_addr", cur_pc + np, prog_addr);
                np++;
            end
            @(posedge clk);
            #1;
            n++;
        end
        chk("cycles", cyc, n);
        chk("fetches", len, np);
        chk("mode", m, mode);
        chk("pc", npc, pc);
        cur_pc = npc;
    endtask

    task automatic t_reset;
        chk("mode", M_INH, mode);
        chk("pc", 12'h000, pc);
        chk("done", 1'b0, done);
        chk("data_we", 1'b0, data_we);
    endtask

    task automatic t_load_modes;
        int i;
        exec(8'hC0, 8'h5A, 8'h00, 2, M_IMM, cur_pc + 12'h002, 5);
        chk("operand", 8'h5A, operand);
        exec(8'hD0, 8'hFF, 8'h00, 2, M_DIR, cur_pc + 12'h002, 5);
        chk("eff_addr", 8'hFF, eff_addr);
        for (i = 0; i < 4; i++) begin
            exec(8'hC8 | 8'(i), 8'h00, 8'h00, 1, M_SDIR, cur_pc + 12'h001, 4);
            chk("eff_addr", 8'h80 + 8'(i), eff_addr);
        end
        core_mem_model_inst.data_mem[8'h80] = 8'h11;
        core_mem_model_inst.data_mem[8'h81] = 8'h22;
        exec(8'hE0, 8'h00, 8'h00, 1, M_IND, cur_pc + 12'h001, 5);
        chk("eff_addr", 8'h11, eff_addr);
        exec(8'hF0, 8'h00, 8'h00, 1, M_IND, cur_pc + 12'h001, 5);
        chk("eff_addr", 8'h22, eff_addr);
        chk("data_addr", 8'h81, data_addr);
    endtask

    task automatic t_bit_direct;
        core_mem_model_inst.data_mem[8'h40] = 8'h81;
        exec(8'hAD, 8'h40, 8'h00, 2, M_BITD, cur_pc + 12'h002, 6);
        chk("data", 8'hA1, core_mem_model_inst.data_mem[8'h40]);
        chk("data_wdata", 8'hA1, data_wdata);
        chk("carry", 1'b0, carry);
        chk("bit_sel", 3'h5, bit_sel);
        exec(8'hA5, 8'h40, 8'h00, 2, M_BITD, cur_pc + 12'h002, 6);
        chk("data", 8'h81, core_mem_model_inst.data_mem[8'h40]);
        chk("carry", 1'b1, carry);
    endtask

    task automatic t_relative;
        zero_flag = 1'b1;
        exec(8'h4F, 8'h00, 8'h00, 1, M_REL, cur_pc + 12'h010, 4);
        chk("branch_taken", 1'b1, branch_taken);
        exec(8'h7F, 8'h00, 8'h00, 1, M_REL, cur_pc + 12'h001, 4);
        chk("branch_taken", 1'b0, branch_taken);
        zero_flag = 1'b0;
        exec(8'h7F, 8'h00, 8'h00, 1, M_REL, cur_pc - 12'h00F, 4);
        exec(8'h03, 8'h00, 8'h00, 1, M_REL, cur_pc + 12'h004, 4);
        exec(8'h23, 8'h00, 8'h00, 1, M_REL, cur_pc + 12'h001, 4);
    endtask

    task automatic t_extended;
        exec(8'h8A, 8'hBC, 8'h00, 2, M_EXT, 12'hABC, 5);
        chk("target", 12'hABC, target);
        exec(8'h9F, 8'h00, 8'h00, 2, M_EXT, 12'hF00, 5);
        exec(8'h91, 8'h23, 8'h00, 2, M_EXT, 12'h123, 5);
        exec(8'hD8, 8'h00, 8'h00, 1, M_INH, 12'hF02, 4);
        exec(8'hD8, 8'h00, 8'h00, 1, M_INH, 12'hABE, 4);
        exec(8'hD9, 8'h00, 8'h00, 1, M_INH, 12'hABF, 4);
    endtask

    task automatic t_bit_test;
        core_mem_model_inst.data_mem[8'h55] = 8'h02;
        exec(8'hB9, 8'h55, 8'h7F, 3, M_BTB, cur_pc + 12'h080, 7);
        chk("carry", 1'b1, carry);
        exec(8'hB1, 8'h55, 8'h80, 3, M_BTB, cur_pc + 12'h003, 7);
        core_mem_model_inst.data_mem[8'h55] = 8'h00;
        exec(8'hB1, 8'h55, 8'h80, 3, M_BTB, cur_pc - 12'h07F, 7);
        chk("carry", 1'b0, carry);
    endtask

    // Reset lands in mid-decode; the next instruction starts again at address 0
    task automatic t_mid_reset;
        core_mem_model_inst.prog_mem[cur_pc] = 8'hD9;
        run = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b1;
        run = 1'b0;
        @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        cur_pc = 12'h000;
        exec(8'hD9, 8'h00, 8'h00, 1, M_INH, 12'h001, 4);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(100 * 3000);
        fail_count++;
        test_done();
    end

    initial begin
        sys_rst = 1'b1;
        run = 1'b0;
        zero_flag = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_load_modes();
        t_bit_direct();
        t_relative();
        t_extended();
        t_bit_test();
        t_mid_reset();
        test_done();
    end
endmodule
`default_nettype wire
